// ---- hw/audio_dac_irq_consts.svh ----
`ifndef AUDIO_DAC_IRQ_CONSTS_SVH
`define AUDIO_DAC_IRQ_CONSTS_SVH

// Byte offsets of the word registers
`define IRQ_ENABLE_OFS 8'h14
`define IRQ_DISABLE_OFS 8'h18
`define IRQ_MASK_OFS 8'h1C
`define STATUS_OFS 8'h20
`define STATUS_CLEAR_OFS 8'h24

// Low address bits that take part in the decode
`define REG_ADDR_BITS 8

// Field positions shared by enable, disable, mask, status and clear
`define TRANSMIT_READY_FLAG_BIT 1
`define TRANSMIT_UNDERRUN_FLAG_BIT 2
`define SRC_BITS 3

// Bits that carry a source; bit 0 is held at zero here
`define SRC_FIELD 3'h6

// Reset values
`define MASK_RESET 3'h0
`define STATUS_RESET 3'h0

`endif

// ---- hw/audio_dac_irq_mask.sv ----
`include "audio_dac_irq_consts.svh"
`default_nettype none

// Functional notes
// R01 - Disable register bits written zero leave the mask bit unchanged.
// R02 - Disable register bit written one clears the matching mask bit.
// R03 - Mask reads 1 enabled, 0 disabled; underrun bit 2, ready bit 1.
// R04 - Enable register bit written one sets the matching mask bit.
// R05 - Ready flag is high exactly while the converter takes a new sample.
// R06 - Underrun flag sets on any underrun, holds until reset or clear write.
// R07 - Interrupt line is high while any set flag has its mask bit set.
module audio_dac_irq_mask
	import audio_dac_irq_pkg::*;
(
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic TX_READY,
	input wire logic TX_UNDERRUN,
	output logic IRQ
);
	irq_ctl_if ctl ();

	logic take;
	logic dp_valid;
	logic dp_write;
	logic dp_hit;
	logic [`REG_ADDR_BITS-1:0] dp_addr;
	logic wr_act;
	logic rd_act;
	bus_state_t state;
	logic [31:0] rd_word;

	// Only word transfers are served; other sizes are accepted but treated as unmapped
	assign take = HSEL & HTRANS[1] & HREADY;

	// Address phase capture
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_hit <= 1'b0;
			dp_addr <= '0;
		end else if (take) begin
			dp_valid <= 1'b1;
			dp_write <= HWRITE;
			dp_hit <= (HADDR[31:`REG_ADDR_BITS] == '0) && (HSIZE == 3'h2);
			dp_addr <= HADDR[`REG_ADDR_BITS-1:0];
		end else if (HREADYOUT) begin
			dp_valid <= 1'b0;
		end
	end

	// Reads take one wait state so the read word comes from a flip-flop
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= BUS_IDLE;
		end else if (rd_act) begin
			state <= BUS_RD_DONE;
		end else begin
			state <= BUS_IDLE;
		end
	end

	assign rd_act = dp_valid & ~dp_write & (state == BUS_IDLE);
	assign wr_act = dp_valid & dp_write & dp_hit;
	assign HREADYOUT = ~rd_act;
	assign HRESP = 1'b0;

	// Write strobes in the data phase, unmapped writes are dropped
	always_comb begin
		ctl.enable_wr = wr_act && (dp_addr == `IRQ_ENABLE_OFS); // see R04
		ctl.disable_wr = wr_act && (dp_addr == `IRQ_DISABLE_OFS); // see R02
		ctl.clear_wr = wr_act && (dp_addr == `STATUS_CLEAR_OFS); // see R06
		ctl.wr_bits = HWDATA[`SRC_BITS-1:0];
	end

	// Read decode; write-only and unmapped words read zero
	always_comb begin
		rd_word = 32'h00000000;
		if (dp_hit && (dp_addr == `IRQ_MASK_OFS)) begin
			rd_word[`SRC_BITS-1:0] = ctl.mask; // see R03
		end else if (dp_hit && (dp_addr == `STATUS_OFS)) begin
			rd_word[`SRC_BITS-1:0] = ctl.status; // see R05
		end
	end

	// Read data register, loaded in the wait cycle
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			HRDATA <= 32'h00000000;
		end else if (rd_act) begin
			HRDATA <= rd_word;
		end
	end

	irq_flag_bank bank (
		.clk(CLK),
		.arst_n(ARST_N),
		.tx_ready(TX_READY),
		.tx_underrun(TX_UNDERRUN),
		.ctl(ctl)
	);

	assign IRQ = ctl.irq; // see R07
endmodule

`default_nettype wire

// ---- hw/audio_dac_irq_pkg.sv ----
`include "audio_dac_irq_consts.svh"
`default_nettype none

package audio_dac_irq_pkg;

	// One bit per source position, bit 0 unused
	typedef logic [`SRC_BITS-1:0] src_vec_t;

	// Bus data phase tracking
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_RD_DONE = 1'b1
	} bus_state_t;

endpackage

`default_nettype wire

// ---- hw/irq_ctl_if.sv ----
`default_nettype none

interface irq_ctl_if
	import audio_dac_irq_pkg::*;
();
	logic enable_wr;
	logic disable_wr;
	logic clear_wr;
	src_vec_t wr_bits;
	src_vec_t mask;
	src_vec_t status;
	logic irq;

	// Bus side issues strobes and reads state back
	modport regs (
		output enable_wr,
		output disable_wr,
		output clear_wr,
		output wr_bits,
		input mask,
		input status,
		input irq
	);

	// Flag bank keeps the mask and the status
	modport bank (
		input enable_wr,
		input disable_wr,
		input clear_wr,
		input wr_bits,
		output mask,
		output status,
		output irq
	);
endinterface

`default_nettype wire

// ---- hw/irq_flag_bank.sv ----
`include "audio_dac_irq_consts.svh"
`default_nettype none

module irq_flag_bank
	import audio_dac_irq_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tx_ready,
	input wire logic tx_underrun,
	irq_ctl_if.bank ctl
);
	src_vec_t mask;
	logic underrun;

	// Enable sets, disable clears; a zero bit leaves the mask alone
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask <= `MASK_RESET;
		end else if (ctl.enable_wr) begin
			mask <= mask | (ctl.wr_bits & `SRC_FIELD); // see R04
		end else if (ctl.disable_wr) begin
			mask <= mask & ~(ctl.wr_bits & `SRC_FIELD); // see R01 see R02
		end
	end

	// Sticky underrun; a new underrun wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			underrun <= 1'b0;
		end else begin
			underrun <= tx_underrun | (underrun & ~(ctl.clear_wr & ctl.wr_bits[`TRANSMIT_UNDERRUN_FLAG_BIT])); // see R06
		end
	end

	// Ready follows the converter live, so a clear cannot hide a ready converter
	always_comb begin
		ctl.status = `STATUS_RESET;
		ctl.status[`TRANSMIT_READY_FLAG_BIT] = tx_ready; // see R05
		ctl.status[`TRANSMIT_UNDERRUN_FLAG_BIT] = underrun;
	end

	assign ctl.mask = mask; // see R03
	assign ctl.irq = |(ctl.status & mask); // see R07
endmodule

`default_nettype wire

// ---- sim/irq_mask_properties.sv ----
`default_nettype none
module irq_mask_chk (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADYOUT,
	input wire logic [31:0] HRDATA,
	input wire logic TX_READY,
	input wire logic IRQ
);
	logic w, r;
	logic [7:0] a;
	logic [1:0] m;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// Data phase, held through the read wait state
	always_ff @(posedge CLK or negedge ARST_N)
		if (!ARST_N) {w, r} <= 2'h0;
		else if (HREADYOUT) {w, r, a} <= {HTRANS[1] & HWRITE, HTRANS[1] & !HWRITE, HADDR[7:0]};
	// Mask shadow; enable and disable never share a cycle
	always_ff @(posedge CLK or negedge ARST_N)
		if (!ARST_N) m <= 2'h0;
		else if (w && a == 8'h14) m <= m | HWDATA[2:1];
		else if (w && a == 8'h18) m <= m & ~HWDATA[2:1];
	a_irq_cause: assert property (IRQ |-> m[2] || m[1] && TX_READY) else $error("irq");
	a_ready_irq: assert property (m[1] && TX_READY |-> IRQ) else $error("ready");
	a_urun_hold: assert property (IRQ && !TX_READY && !w |=> IRQ) else $error("urun");
	a_mask_read: assert property (r && HREADYOUT && a == 8'h1C
		|-> HRDATA == {29'h0, m, 1'h0}) else $error("mask");
	a_dis_clear: assert property (w && a == 8'h18 && HWDATA[2:1] == 2'h3
		|=> !IRQ) else $error("disable");
	a_en_set: assert property (w && a == 8'h14 && HWDATA[1]
		##1 TX_READY |-> IRQ) else $error("enable");
	a_dis_keep: assert property (w && a == 8'h18 && HWDATA[2:1] == 2'h0 && IRQ
		##1 $stable(TX_READY) |-> IRQ) else $error("keep");
endmodule
bind audio_dac_irq_mask irq_mask_chk i_chk (.*);
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns / 1ns;
	logic CLK, ARST_N, HWRITE, TX_READY, TX_UNDERRUN;
	logic [1:0] HTRANS;
	logic [31:0] HADDR, HWDATA;
	wire HREADYOUT, IRQ, HRESP;
	wire [31:0] HRDATA;
	int n_errors, checked;
	audio_dac_irq_mask i_dut (.*, .HSEL(1'h1), .HSIZE(3'h2), .HREADY(HREADYOUT));
	// Clock
	initial begin
		CLK = 1'h0;
		forever #5 CLK = ~CLK;
	end
	task automatic conclude;
		$display("%0d errors, %0d checks", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	endtask
	// A hang ends the run instead of stalling it
	task automatic wt;
		repeat (9) begin
			@(posedge CLK);
			if (HREADYOUT === 1'h1) return;
		end
		n_errors++;
		conclude;
	endtask
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		wt;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wt;
		chk(HRESP, 1'h0); // Response is always OKAY
		if (!w) chk(HRDATA, d);
	endtask
	task automatic ci(input logic e);
		@(posedge CLK);
		chk(IRQ, e);
	endtask
	// Reset, then mask and interrupt traffic
	initial begin
		ARST_N = 1'h0;
		{HWRITE, TX_READY, TX_UNDERRUN} = 3'h0;
		{HTRANS, HADDR, HWDATA} = 66'h0;
		repeat (2) @(posedge CLK);
		ARST_N <= 1'h1;
		xf(1'h0, 8'h1C, 32'h0);
		TX_READY <= 1'h1;
		xf(1'h1, 8'h14, 32'h2);
		ci(1'h1);
		xf(1'h1, 8'h18, 32'hFFFFFFF9);
		xf(1'h0, 8'h1C, 32'h2);
		{TX_READY, TX_UNDERRUN} <= 2'h1;
		ci(1'h0);
		TX_UNDERRUN <= 1'h0;
		xf(1'h1, 8'h14, 32'h4);
		ci(1'h1);
		xf(1'h0, 8'h20, 32'h4);
		xf(1'h0, 8'h1C, 32'h6);
		xf(1'h1, 8'h24, 32'h4);
		ci(1'h0);
		TX_READY <= 1'h1;
		xf(1'h1, 8'h18, 32'h6);
		ci(1'h0);
		xf(1'h0, 8'h20, 32'h2);
		xf(1'h0, 8'h40, 32'h0);
		conclude;
	end
endmodule
`default_nettype wire
